// ---- rtl/dstf_regs.svh ----
// Behaviour
// [RULE1] start, eight data, parity, stop: eleven bits
// [RULE2] parity makes data plus parity ones even
// [RULE3] telegram: start 02, length, address, data, checksum
// [RULE4] length counts data, address and checksum bytes
// [RULE5] text telegram length is ten plus characters
// [RULE6] short address: bit7 clear, bits 0-4 station
// [RULE7] short format bit5 set means broadcast
// [RULE8] long address: bit7 set, bits 0-6 station
// [RULE9] long format all-zero station means broadcast
// [RULE10] reply echoes received address byte unchanged
// [RULE11] checksum is running xor from zero
// [RULE12] reply only to clean telegram for us
// [RULE13] broadcast accepted but never answered
// [RULE14] reply after two characters, within 20 ms
// [RULE15] master pauses two characters after reply
// [RULE16] gap two characters, telegram within 1.5 times
// [RULE17] parameter block is twelve bytes
// [RULE18] process block is two words
// [RULE19] text block: identifier, index, text, process words
// [RULE20] line rate matches master, set by configuration
// [RULE21] framing active only when protocol select zero
// [RULE22] identifier bits 12-15 carry command or reply
// [RULE23] failed command replies 0111 with error number
// [RULE24] identifier bits 0-10 carry parameter number
// [RULE25] drop telegram on parity, checksum, length, gap
// [RULE26] reply checksum covers every byte before it
`ifndef DSTF_REGS_SVH
`define DSTF_REGS_SVH
`define DSTF_STX 8'h02
`define DSTF_DATA_BITS 4'h9
`define DSTF_CHAR_BITS 32'h0000000b
`define DSTF_GAP_BITS 6'h16
`define DSTF_OVH 8'h02
`define DSTF_HDR 8'h03
`define DSTF_POS_LEN 8'h01
`define DSTF_POS_ADR 8'h02
`define DSTF_LEN_MIN 8'h02
`define DSTF_LEN_TEXT_FIX 8'h0a
`define DSTF_LEN_PARAM 8'h0e
`define DSTF_ADR_LONG 7
`define DSTF_ADR_BCAST 5
`define DSTF_SHORT_W 5
`define DSTF_CMD_FAIL 4'h7
`define DSTF_PKE_HI 8'h00
`define DSTF_PKE_LO 8'h01
`define DSTF_PWE_FIRST 8'h04
`define DSTF_PWE_LAST 8'h07
`define DSTF_PROTO_FRAMER 8'h00
`define DSTF_CLK_HZ 32'd100000000
`define DSTF_RESP_MAX_MS 32'd20
`define DSTF_RESP_MAX_CYC (`DSTF_RESP_MAX_MS * (`DSTF_CLK_HZ / 32'd1000))
`endif

// ---- rtl/dstf_pkg.sv ----
package dstf_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} dstf_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} dstf_tx_st_t;
endpackage

// ---- rtl/dstf_framer.sv ----
`timescale 1ns/1ns
`include "dstf_regs.svh"
module dstf_framer #(
  parameter int MAXB = 32,
  parameter int unsigned RESP_MAX_CYC = `DSTF_RESP_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] baudDiv,
  input wire logic [7:0] protocolSel,
  input wire logic [6:0] stationAddr,
  input wire logic rxLine,
  output logic txLine,
  output logic txEn,
  output logic telegramDone,
  output logic telegramBcast,
  output logic [7:0] telegramLen,
  output logic [7:0] rxAddress,
  output logic [3:0] errFlags,
  output logic [3:0] parameterCommandField,
  output logic [10:0] parameterNumberField,
  input wire logic [7:0] rdIdx,
  output logic [7:0] rdData,
  input wire logic txWrEn,
  input wire logic [7:0] txWrIdx,
  input wire logic [7:0] txWrData,
  input wire logic [7:0] replyLen,
  input wire logic replyGo,
  input wire logic cmdFail,
  input wire logic [7:0] errNum,
  output logic replyPending,
  output logic replyDone,
  output logic replyTimeout
);

  typedef struct packed {
    dstf_pkg::dstf_rx_st_t rxSt;
    logic [15:0] rxDiv;
    logic [3:0] rxBit;
    logic [8:0] rxSh;
    logic [15:0] tk;
    logic fActive;
    logic [7:0] pos;
    logic [7:0] len;
    logic [7:0] runningChecksum;
    logic bad;
    logic [5:0] gapBits;
    logic [15:0] durBits;
    logic [MAXB-1:0][7:0] rxBuf;
    dstf_pkg::dstf_tx_st_t txSt;
    logic [5:0] waitBits;
    logic [31:0] waitCyc;
    logic goSeen;
    logic fail;
    logic [7:0] errNum;
    logic [MAXB-1:0][7:0] txBuf;
    logic [7:0] txPos;
    logic [7:0] txLen;
    logic [7:0] txSum;
    logic [10:0] txSh;
    logic [3:0] txBit;
    logic [15:0] txDiv;
    logic txLine;
    logic txEn;
    logic done;
    logic bcast;
    logic [7:0] telLen;
    logic [7:0] addr;
    logic [3:0] errFlags;
    logic [3:0] cmd;
    logic [10:0] pnum;
    logic [7:0] rdData;
    logic replyPend;
    logic replyDone;
    logic replyTimeout;
  } dstf_state_t;

  dstf_state_t r;
  dstf_state_t n;

  // even parity over a data byte; used on both receive and transmit
  function automatic logic evenPar(input logic [7:0] b);
    return ^b; // [RULE2]
  endfunction

  // process image: uart rx, telegram parser, reply sequencer, uart tx
  always_comb begin
    logic tick;
    logic chDone;
    logic chBad;
    logic [7:0] chByte;
    logic [7:0] sumNxt;
    logic [7:0] di;
    logic [7:0] tb;
    logic bc;
    logic mine;
    logic [31:0] durLim;
    tick = 1'b0;
    chDone = 1'b0;
    chBad = 1'b0;
    chByte = r.rxSh[7:0];
    sumNxt = 8'h00;
    di = 8'h00;
    tb = 8'h00;
    bc = 1'b0;
    mine = 1'b0;
    durLim = 32'h0;
    n = r;
    n.done = 1'b0;
    n.errFlags = 4'h0;
    n.replyDone = 1'b0;
    n.replyTimeout = 1'b0;

    // free bit-time tick, paced by the configured rate
    if (r.tk >= baudDiv - 16'h1) begin
      n.tk = 16'h0;
      tick = 1'b1; // [RULE20]
    end else begin
      n.tk = r.tk + 16'h1;
    end

    // receive one character; sample mid-bit from the start edge
    unique case (r.rxSt)
      dstf_pkg::RX_IDLE: begin
        if (!rxLine) begin
          n.rxSt = dstf_pkg::RX_START;
          n.rxDiv = baudDiv >> 1;
        end
      end
      dstf_pkg::RX_START: begin
        if (r.rxDiv == 16'h0) begin
          n.rxSt = rxLine ? dstf_pkg::RX_IDLE : dstf_pkg::RX_BITS;
          n.rxDiv = baudDiv - 16'h1;
          n.rxBit = 4'h0;
          n.gapBits = 6'h0;
        end else begin
          n.rxDiv = r.rxDiv - 16'h1;
        end
      end
      dstf_pkg::RX_BITS: begin
        if (r.rxDiv == 16'h0) begin
          n.rxSh = {rxLine, r.rxSh[8:1]};
          n.rxDiv = baudDiv - 16'h1;
          n.rxBit = r.rxBit + 4'h1;
          if (r.rxBit == `DSTF_DATA_BITS - 4'h1) begin
            n.rxSt = dstf_pkg::RX_STOP; // [RULE1]
          end
        end else begin
          n.rxDiv = r.rxDiv - 16'h1;
        end
      end
      dstf_pkg::RX_STOP: begin
        if (r.rxDiv == 16'h0) begin
          n.rxSt = dstf_pkg::RX_IDLE;
          chDone = 1'b1;
          // a missing stop bit is treated like a parity fault
          chBad = (evenPar(r.rxSh[7:0]) != r.rxSh[8]) || !rxLine; // [RULE2]
        end else begin
          n.rxDiv = r.rxDiv - 16'h1;
        end
      end
    endcase

    // telegram watchdogs: character gap and total duration
    durLim = `DSTF_CHAR_BITS * (32'(r.len) + 32'(`DSTF_OVH)) * 32'h3;
    if (r.fActive && tick) begin
      n.durBits = r.durBits + 16'h1;
      if (r.rxSt == dstf_pkg::RX_IDLE) begin
        n.gapBits = r.gapBits + 6'h1;
      end
      if ((r.rxSt == dstf_pkg::RX_IDLE && r.gapBits >= `DSTF_GAP_BITS) ||
          (r.pos > `DSTF_POS_LEN && 32'(r.durBits) * 32'h2 > durLim)) begin
        n.fActive = 1'b0; // [RULE16]
        n.errFlags[3] = 1'b1; // [RULE25]
      end
    end

    // parse bytes into the telegram
    sumNxt = r.runningChecksum ^ chByte; // [RULE11]
    if (chDone && !r.fActive && chByte == `DSTF_STX && !chBad) begin
      n.fActive = 1'b1; // [RULE3]
      n.pos = `DSTF_POS_LEN;
      n.runningChecksum = chByte; // [RULE11]
      n.bad = 1'b0;
      n.durBits = 16'h0;
      n.len = 8'h0;
    end else if (chDone && r.fActive) begin
      n.pos = r.pos + 8'h1;
      n.runningChecksum = sumNxt;
      n.bad = r.bad | chBad;
      if (r.pos == `DSTF_POS_LEN) begin
        n.len = chByte;
        // data must fit the buffer; text is 10 fixed plus chars
        if (chByte < `DSTF_LEN_MIN || 32'(chByte) > MAXB + 2) begin
          n.fActive = 1'b0; // [RULE4]
          n.errFlags[2] = 1'b1; // [RULE25]
        end
      end else if (r.pos == `DSTF_POS_ADR) begin
        n.addr = chByte;
      end else if (r.pos <= r.len) begin
        n.rxBuf[r.pos - `DSTF_HDR] = chByte; // [RULE17] [RULE18] [RULE19]
      end else begin
        // checksum byte: running xor must now be zero
        n.fActive = 1'b0;
        bc = r.addr[`DSTF_ADR_LONG] ? (r.addr[6:0] == 7'h00)        // [RULE9]
                                    : r.addr[`DSTF_ADR_BCAST];     // [RULE7]
        mine = r.addr[`DSTF_ADR_LONG] ?
               (r.addr[6:0] == stationAddr) :                     // [RULE8]
               (r.addr[4:0] == stationAddr[`DSTF_SHORT_W-1:0] &&
                stationAddr[6:`DSTF_SHORT_W] == 2'h0);            // [RULE6]
        if (r.bad || chBad) begin
          n.errFlags[0] = 1'b1; // [RULE25]
        end else if (sumNxt != 8'h00) begin
          n.errFlags[1] = 1'b1; // [RULE25]
        end else if (protocolSel == `DSTF_PROTO_FRAMER && (bc || mine)) begin
          n.done = 1'b1; // [RULE21]
          n.bcast = bc;
          n.telLen = r.len; // [RULE5]
          n.cmd = r.rxBuf[`DSTF_PKE_HI][7:4]; // [RULE22]
          n.pnum = {r.rxBuf[`DSTF_PKE_HI][2:0],
                    r.rxBuf[`DSTF_PKE_LO]}; // [RULE24]
          if (!bc && r.txSt == dstf_pkg::TX_IDLE) begin
            n.txSt = dstf_pkg::TX_WAIT; // [RULE12] [RULE13]
            n.replyPend = 1'b1;
            n.waitBits = 6'h0;
            n.waitCyc = 32'h0;
            n.goSeen = 1'b0;
          end
        end
      end
    end

    // user access to the data bytes of the last telegram
    n.rdData = (32'(rdIdx) < MAXB) ? r.rxBuf[rdIdx] : 8'h00;
    if (txWrEn && r.txSt != dstf_pkg::TX_SEND && 32'(txWrIdx) < MAXB) begin
      n.txBuf[txWrIdx] = txWrData;
    end

    // reply gating: two character times minimum, 20 ms deadline
    if (r.txSt == dstf_pkg::TX_WAIT) begin
      n.waitCyc = r.waitCyc + 32'h1;
      if (tick && r.waitBits <= `DSTF_GAP_BITS) begin
        n.waitBits = r.waitBits + 6'h1;
      end
      if (replyGo && !r.goSeen) begin
        n.goSeen = 1'b1;
        n.fail = cmdFail;
        n.errNum = errNum;
        n.txLen = replyLen;
      end
      if (r.goSeen && r.waitBits > `DSTF_GAP_BITS) begin
        n.txSt = dstf_pkg::TX_SEND; // [RULE14]
        n.txPos = 8'h0;
        n.txSum = 8'h00;
        n.txBit = 4'hf;
        n.txDiv = 16'h0;
        n.txEn = 1'b1;
      end else if (r.waitCyc >= RESP_MAX_CYC - 32'h1) begin
        // late software loses the reply rather than break timing
        n.txSt = dstf_pkg::TX_IDLE; // [RULE14]
        n.replyPend = 1'b0;
        n.replyTimeout = 1'b1;
      end
    end

    // pick the next reply byte; failed commands rewrite their fields
    di = r.txPos - `DSTF_HDR;
    if (r.txPos == 8'h0) begin
      tb = `DSTF_STX; // [RULE3]
    end else if (r.txPos == `DSTF_POS_LEN) begin
      tb = r.txLen; // [RULE4]
    end else if (r.txPos == `DSTF_POS_ADR) begin
      tb = r.addr; // [RULE10]
    end else if (r.txPos <= r.txLen && 32'(di) < MAXB) begin
      tb = r.txBuf[di];
      if (r.fail && di == `DSTF_PKE_HI) begin
        tb = {`DSTF_CMD_FAIL, r.txBuf[di][3:0]}; // [RULE23]
      end else if (r.fail && di == `DSTF_PWE_LAST) begin
        tb = r.errNum; // [RULE23]
      end else if (r.fail && di >= `DSTF_PWE_FIRST && di < `DSTF_PWE_LAST) begin
        tb = 8'h00;
      end
    end else begin
      tb = r.txSum; // [RULE26]
    end

    // transmit: load a frame, then shift lsb first at bit rate
    if (r.txSt == dstf_pkg::TX_SEND) begin
      if (r.txDiv != 16'h0) begin
        n.txDiv = r.txDiv - 16'h1;
      end else if (r.txBit == 4'hf) begin
        if (r.txPos > r.txLen + 8'h1) begin
          n.txSt = dstf_pkg::TX_IDLE;
          n.txEn = 1'b0;
          n.txLine = 1'b1;
          n.replyPend = 1'b0;
          n.replyDone = 1'b1;
        end else begin
          n.txSh = {1'b1, evenPar(tb), tb, 1'b0}; // [RULE1] [RULE2]
          n.txSum = r.txSum ^ tb; // [RULE11] [RULE26]
          n.txPos = r.txPos + 8'h1;
          n.txBit = 4'h0;
        end
      end else begin
        n.txLine = r.txSh[0];
        n.txSh = {1'b1, r.txSh[10:1]};
        n.txDiv = baudDiv - 16'h1;
        n.txBit = (32'(r.txBit) == `DSTF_CHAR_BITS - 32'h1) ?
                  4'hf : r.txBit + 4'h1;
      end
    end
  end

  // one register bank for the whole state; idle line is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.txLine <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign txLine = r.txLine;
  assign txEn = r.txEn;
  assign telegramDone = r.done;
  assign telegramBcast = r.bcast;
  assign telegramLen = r.telLen;
  assign rxAddress = r.addr;
  assign errFlags = r.errFlags;
  assign parameterCommandField = r.cmd;
  assign parameterNumberField = r.pnum;
  assign rdData = r.rdData;
  assign replyPending = r.replyPend;
  assign replyDone = r.replyDone;
  assign replyTimeout = r.replyTimeout;

endmodule // dstf_framer

// ---- bench/dstf_framer_checker.sv ----
`timescale 1ns/1ns
module dstf_framer_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] baudDiv,
  input wire logic [7:0] protocolSel,
  input wire logic [6:0] stationAddr,
  input wire logic txLine,
  input wire logic txEn,
  input wire logic telegramDone,
  input wire logic telegramBcast,
  input wire logic [7:0] rxAddress,
  input wire logic [3:0] errFlags,
  input wire logic replyPending,
  input wire logic replyTimeout
);
  logic [31:0] gapCnt;
  // cycles since the last accepted telegram, saturating to stay bounded
  always_ff @(posedge clk) begin
    if (!rst_n || telegramDone) gapCnt <= '0;
    else if (gapCnt != 32'hffffffff) gapCnt <= gapCnt + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_idle; !txEn |-> txLine; endproperty
  a_idle: assert property (p_idle) else $error("tx not idle");
  // one cycle to load the shifter, then the start bit
  property p_start; $rose(txEn) |=> txLine ##1 !txLine ##1 !txLine;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_own; $rose(replyPending) |-> telegramDone && !telegramBcast;
  endproperty
  a_own: assert property (p_own) else $error("bad pend");
  property p_txreq; $rose(txEn) |-> replyPending; endproperty
  a_txreq: assert property (p_txreq) else $error("reply unasked");
  property p_gap; $rose(txEn) |-> gapCnt >= 22 * baudDiv; endproperty
  a_gap: assert property (p_gap) else $error("reply too early");
  property p_clean; telegramDone |-> errFlags == 4'h0 && protocolSel == 8'h00;
  endproperty
  a_clean: assert property (p_clean) else $error("bad accept");
  property p_match; telegramDone && !telegramBcast |-> (rxAddress[7] ?
    rxAddress[6:0] == stationAddr : {2'h0, rxAddress[5:0]} == stationAddr);
  endproperty
  a_match: assert property (p_match) else $error("foreign");
  property p_bcast; telegramDone && telegramBcast |->
    (rxAddress[7] ? rxAddress[6:0] == 7'h00 : rxAddress[5]); endproperty
  a_bcast: assert property (p_bcast) else $error("bad bcast");
  property p_tout; replyTimeout |=> !replyPending && !txEn; endproperty
  a_tout: assert property (p_tout) else $error("timeout kept");
endmodule // dstf_framer_checker
bind dstf_framer dstf_framer_checker chk (.clk(clk), .rst_n(rst_n),
  .baudDiv(baudDiv), .protocolSel(protocolSel), .stationAddr(stationAddr),
  .txLine(txLine), .txEn(txEn), .telegramDone(telegramDone),
  .telegramBcast(telegramBcast), .rxAddress(rxAddress), .errFlags(errFlags),
  .replyPending(replyPending), .replyTimeout(replyTimeout));

// ---- bench/dstf_master_model.sv ----
`timescale 1ns/1ns
module dstf_master_model (
  input wire logic clk,
  input wire logic [15:0] baudDiv,
  input wire logic txLine,
  output logic rxLine
);
  // line rests high between characters
  initial rxLine = 1'b1;
  // start, data lsb first, even parity, stop
  task automatic send_byte(input logic [7:0] b, input logic badPar);
    logic [10:0] f;
    f = {1'b1, ^b ^ badPar, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk) rxLine = f[i];
      repeat (baudDiv - 16'h1) @(negedge clk);
    end
  endtask
  // bounded wait for a start bit, then sample mid-cell
  task automatic get_byte(output logic [7:0] b, output logic ok);
    logic [10:0] f;
    int n;
    n = 0;
    while (txLine !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (baudDiv / 16'h2) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txLine;
      if (i < 10) repeat (baudDiv) @(negedge clk);
    end
    b = f[8:1];
    ok = n < 4000 && f[0] === 1'b0 && f[10] === 1'b1;
    ok = ok && ^f[9:1] === 1'b0;
  endtask
endmodule // dstf_master_model

// ---- bench/tb_drive_serial_telegram_framer.sv ----
`timescale 1ns/1ns
module tb_drive_serial_telegram_framer;
  localparam int BD = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] baudDiv = 16'(BD);
  logic [7:0] protocolSel = 8'h00;
  logic [6:0] stationAddr = 7'h16;
  logic rxLine, txLine, txEn, telegramDone, telegramBcast;
  logic [7:0] telegramLen, rxAddress, rdData;
  logic [3:0] errFlags, parameterCommandField;
  logic [3:0] errSeen = 4'h0;
  logic [10:0] parameterNumberField;
  logic [7:0] rdIdx = 8'h00, txWrIdx = 8'h00, txWrData = 8'h00;
  logic [7:0] replyLen = 8'h00, errNum = 8'h00;
  logic txWrEn = 1'b0, replyGo = 1'b0, cmdFail = 1'b0;
  logic replyPending, replyDone, replyTimeout;
  logic [7:0] txd [16];
  int miscompares = 0, checked = 0, doneCnt = 0, toCnt = 0, replyCnt = 0;
  // short bit time and response limit keep the run brief
  always #5 clk = ~clk;
  dstf_framer #(.MAXB(32), .RESP_MAX_CYC(2000)) dut (.clk(clk),
    .rst_n(rst_n), .baudDiv(baudDiv), .protocolSel(protocolSel),
    .stationAddr(stationAddr), .rxLine(rxLine), .txLine(txLine),
    .txEn(txEn), .telegramDone(telegramDone), .telegramBcast(telegramBcast),
    .telegramLen(telegramLen), .rxAddress(rxAddress), .errFlags(errFlags),
    .parameterCommandField(parameterCommandField),
    .parameterNumberField(parameterNumberField), .rdIdx(rdIdx),
    .rdData(rdData), .txWrEn(txWrEn), .txWrIdx(txWrIdx),
    .txWrData(txWrData), .replyLen(replyLen), .replyGo(replyGo),
    .cmdFail(cmdFail), .errNum(errNum), .replyPending(replyPending),
    .replyDone(replyDone), .replyTimeout(replyTimeout));
  dstf_master_model m (.clk(clk), .baudDiv(baudDiv), .txLine(txLine),
    .rxLine(rxLine));
  // pulses are one cycle wide, so gather them for the tasks
  always @(posedge clk) begin
    if (telegramDone === 1'b1) doneCnt <= doneCnt + 1;
    if (replyTimeout === 1'b1) toCnt <= toCnt + 1;
    if (replyDone === 1'b1) replyCnt <= replyCnt + 1;
    errSeen <= errSeen | errFlags;
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // whole telegram with running xor, optionally spoiled
  task automatic send_tel(input logic [7:0] adr, input int n,
    input logic badSum, input logic badPar);
    logic [7:0] s, b;
    s = 8'h00;
    for (int i = 0; i < n + 4; i++) begin
      if (i == 0) b = 8'h02;
      else if (i == 1) b = 8'(n + 2);
      else if (i == 2) b = adr;
      else if (i < n + 3) b = txd[i-3];
      else b = s ^ {7'h0, badSum};
      s = s ^ b;
      m.send_byte(b, badPar && i == 3);
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic run_reply(input logic [7:0] adr, input int n,
    input logic fail);
    logic [7:0] e, s, b;
    logic ok;
    int k;
    doneCnt = 0;
    replyCnt = 0;
    for (int i = 0; i < n; i++) txd[i] = 8'(8'h10 + i * 7);
    send_tel(adr, n, 1'b0, 1'b0);
    check("done", doneCnt, 1);
    check("addr", rxAddress, adr);
    check("len", telegramLen, n + 2);
    check("cmd", parameterCommandField, txd[0][7:4]);
    check("pnu", parameterNumberField, {txd[0][2:0], txd[1]});
    check("pend", replyPending, 1);
    rdIdx = 8'(n - 1);
    repeat (2) @(negedge clk);
    check("rd", rdData, txd[n-1]);
    for (int i = 0; i < n; i++) begin
      txWrEn = 1'b1;
      txWrIdx = 8'(i);
      txWrData = 8'(8'h30 + i);
      @(negedge clk);
    end
    txWrEn = 1'b0;
    replyLen = 8'(n + 2);
    cmdFail = fail;
    errNum = 8'h11;
    replyGo = 1'b1;
    @(negedge clk) replyGo = 1'b0;
    s = 8'h00;
    for (int i = 0; i < n + 4; i++) begin
      k = i - 3;
      m.get_byte(b, ok);
      if (i == 0) e = 8'h02;
      else if (i == 1) e = 8'(n + 2);
      else if (i == 2) e = adr;
      else if (i == n + 3) e = s;
      else if (fail && k == 0) e = 8'h70; // failed-command code in top nibble
      else if (fail && k >= 4 && k <= 6) e = 8'h00;
      else if (fail && k == 7) e = 8'h11;
      else e = 8'(8'h30 + k);
      check("reply", {ok, b}, {1'b1, e});
      s = s ^ e;
    end
    // the last stop bit runs half a bit time past its mid-cell sample
    repeat (BD) @(negedge clk);
    check("pend", replyPending, 0);
    check("txen", txEn, 0);
    check("rdone", replyCnt, 1);
    repeat (23 * BD) @(negedge clk);
  endtask
  task automatic t_short_fail;
    run_reply(8'h56, 12, 1'b1);
  endtask
  task automatic t_long_ok;
    run_reply(8'h96, 4, 1'b0);
  endtask
  task automatic t_bcast;
    logic [7:0] a [2];
    a = '{8'h3f, 8'h80};
    for (int k = 0; k < 2; k++) begin
      doneCnt = 0;
      send_tel(a[k], 4, 1'b0, 1'b0);
      check("done", doneCnt, 1);
      check("bcast", telegramBcast, 1);
      repeat (30 * BD) @(negedge clk);
      check("txen", txEn | replyPending, 0);
    end
  endtask
  // bad checksum, bad parity, foreign short, foreign long, other protocol
  task automatic t_drop;
    logic [7:0] a [5];
    a = '{8'h16, 8'h16, 8'h15, 8'h97, 8'h16};
    for (int k = 0; k < 5; k++) begin
      doneCnt = 0;
      errSeen = 4'h0;
      protocolSel = (k == 4) ? 8'h01 : 8'h00;
      send_tel(a[k], 4, k == 0, k == 1);
      check("drop", doneCnt + replyPending, 0);
      check("err", errSeen[k == 1 ? 0 : 1], k < 2);
      repeat (30 * BD) @(negedge clk);
    end
    protocolSel = 8'h00;
  endtask
  // length byte below the minimum, then a telegram left unfinished
  task automatic t_faults;
    doneCnt = 0;
    errSeen = 4'h0;
    m.send_byte(8'h02, 1'b0);
    m.send_byte(8'h01, 1'b0);
    repeat (4) @(negedge clk);
    check("lenerr", errSeen, 4'h4);
    errSeen = 4'h0;
    m.send_byte(8'h02, 1'b0);
    m.send_byte(8'h06, 1'b0);
    repeat (30 * BD) @(negedge clk);
    check("gaperr", errSeen, 4'h8);
    check("quiet", doneCnt + replyPending, 0);
  endtask
  task automatic t_timeout;
    toCnt = 0;
    send_tel(8'h16, 4, 1'b0, 1'b0);
    check("pend", replyPending, 1);
    check("bcast", telegramBcast, 0);
    repeat (2100) @(negedge clk);
    check("tout", toCnt, 1);
    check("quiet", txEn | replyPending, 0);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog sized well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_short_fail;
    t_long_ok;
    t_bcast;
    t_drop;
    t_faults;
    t_timeout;
    give_verdict;
  end
endmodule // tb_drive_serial_telegram_framer
